// >>> rtl/ldlrb_bank.sv
// Low register bank (00h-1Fh) with bank selector for 20h-6Fh
//
// How it works
// R01: Unused bit positions of the low bank always read back as zero.
// R02: Host leaves sub-address 04h at zero; it stores nothing here.
// R03: Two-bit bank selector picks one of four maps for 20h-6Fh.
// R04: Selector 00 routes switched range to LED channel one-to-ten registers.
// R05: Selector 01 routes switched range to modulated-light registers.
// R06: Selector 10 routes switched range to pattern memory one and matrix.
// R07: Selector 11 routes switched range to pattern memory two and matrix.
// R08: Reset loads defaults; read-only ignores writes; clear registers read zero.
`timescale 1ns/1ps

module ldlrb_bank (
	// Clock and reset
	input  wire logic                MCLK_I,
	input  wire logic                RST_N_I,
	// Host register access
	input  wire ldlrb_pkg::ldlrb_req_t REQ_I,
	output logic [7:0]               RDATA_O,
	output logic                     RVALID_O,
	// Hardware events and state
	input  wire logic [7:0]          EVT_A_I,
	input  wire logic [7:0]          EVT_B_I,
	input  wire ldlrb_pkg::ldlrb_hw_t HW_I,
	// Switched range forwarding
	output logic                     SW_WR_O,
	output logic                     SW_RD_O,
	output logic [6:0]               SW_ADDR_O,
	output logic [7:0]               SW_WDATA_O,
	output logic [3:0]               SW_MAP_SEL_O,
	input  wire logic [7:0]          SW_RDATA_I,
	// Control register contents
	output logic [7:0]               CTRL_O [32],
	output logic [7:0]               IRQ_PEND_A_O,
	output logic [7:0]               IRQ_PEND_B_O
);

	// ==========================================================
	// Decode helpers
	function automatic logic is_low(input logic [6:0] a);
		is_low = (a < ldlrb_pkg::OFS_SWITCHED_FIRST);
	endfunction

	function automatic logic is_switched(input logic [6:0] a);
		is_switched = (a >= ldlrb_pkg::OFS_SWITCHED_FIRST) &&
			(a <= ldlrb_pkg::OFS_SWITCHED_LAST);
	endfunction

	function automatic logic is_host_writable(input logic [6:0] a);
		unique case (a)
			ldlrb_pkg::OFS_PUMP_STATE,
			ldlrb_pkg::OFS_FACTORY_TEST,
			ldlrb_pkg::OFS_IRQ_STATUS_A,
			ldlrb_pkg::OFS_IRQ_CLEAR_A,
			ldlrb_pkg::OFS_IRQ_STATUS_B,
			ldlrb_pkg::OFS_IRQ_CLEAR_B,
			ldlrb_pkg::OFS_SENSOR_RESULT_LOW,
			ldlrb_pkg::OFS_SENSOR_RESULT_HIGH: is_host_writable = 1'b0; // R08
			default: is_host_writable = 1'b1;
		endcase
	endfunction

	// ==========================================================
	// Plain read/write storage
	logic [7:0] regs_r [32];
	logic       wr_low;
	logic [4:0] wr_idx;

	assign wr_low = REQ_I.wr_en && is_low(REQ_I.addr);
	assign wr_idx = REQ_I.addr[4:0];

	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_reg
			always_ff @(posedge MCLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					regs_r[g] <= ldlrb_pkg::RESET_VAL[g]; // R08
				end else if (wr_low && wr_idx == 5'(g) &&
					is_host_writable(7'(g))) begin
					// Unused positions never hold a one
					regs_r[g] <= REQ_I.wdata &
						ldlrb_pkg::FIELD_MASK[g]; // R01 R02
				end
			end
			assign CTRL_O[g] = regs_r[g];
		end
	endgenerate

	// ==========================================================
	// Sticky interrupt status, set wins over clear
	logic [7:0] pend_a_r;
	logic [7:0] pend_b_r;
	logic [7:0] clr_a;
	logic [7:0] clr_b;

	assign clr_a = (REQ_I.wr_en && REQ_I.addr == ldlrb_pkg::OFS_IRQ_CLEAR_A)
		? (REQ_I.wdata & ldlrb_pkg::FIELD_MASK[12]) : 8'h00;
	assign clr_b = (REQ_I.wr_en && REQ_I.addr == ldlrb_pkg::OFS_IRQ_CLEAR_B)
		? (REQ_I.wdata & ldlrb_pkg::FIELD_MASK[22]) : 8'h00;

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pend_a_r <= 8'h00;
		end else begin
			pend_a_r <= ((pend_a_r & ~clr_a) | EVT_A_I) &
				ldlrb_pkg::FIELD_MASK[11];
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pend_b_r <= 8'h00;
		end else begin
			pend_b_r <= ((pend_b_r & ~clr_b) | EVT_B_I) &
				ldlrb_pkg::FIELD_MASK[21];
		end
	end

	assign IRQ_PEND_A_O = pend_a_r & regs_r[13];
	assign IRQ_PEND_B_O = pend_b_r & regs_r[23];

	// ==========================================================
	// Bank selector and switched range forwarding
	ldlrb_pkg::ldlrb_map_t map_sel;
	logic                  sw_hit;

	assign map_sel = ldlrb_pkg::ldlrb_map_t'(regs_r[31][1:0]);
	assign sw_hit  = is_switched(REQ_I.addr); // R03

	always_comb begin
		unique case (map_sel)
			ldlrb_pkg::LDLRB_MAP_LED_CHANNELS: SW_MAP_SEL_O = 4'h1; // R04
			ldlrb_pkg::LDLRB_MAP_MODULATED:    SW_MAP_SEL_O = 4'h2; // R05
			ldlrb_pkg::LDLRB_MAP_PATTERN_ONE:  SW_MAP_SEL_O = 4'h4; // R06
			ldlrb_pkg::LDLRB_MAP_PATTERN_TWO:  SW_MAP_SEL_O = 4'h8; // R07
		endcase
	end

	assign SW_WR_O    = REQ_I.wr_en && sw_hit; // R03
	assign SW_RD_O    = REQ_I.rd_en && sw_hit; // R03
	assign SW_ADDR_O  = REQ_I.addr;
	assign SW_WDATA_O = REQ_I.wdata;

	// ==========================================================
	// Read path, data registered one cycle after the request
	logic [7:0] low_rdata;

	always_comb begin
		unique case (REQ_I.addr)
			ldlrb_pkg::OFS_PUMP_STATE:
				low_rdata = HW_I.pump_state & ldlrb_pkg::FIELD_MASK[2];
			ldlrb_pkg::OFS_IRQ_STATUS_A:  low_rdata = pend_a_r;
			ldlrb_pkg::OFS_IRQ_STATUS_B:  low_rdata = pend_b_r;
			ldlrb_pkg::OFS_IRQ_CLEAR_A,
			ldlrb_pkg::OFS_IRQ_CLEAR_B:   low_rdata = 8'h00; // R08
			ldlrb_pkg::OFS_SENSOR_RESULT_LOW:  low_rdata = HW_I.sensor_low;
			ldlrb_pkg::OFS_SENSOR_RESULT_HIGH: low_rdata = HW_I.sensor_high;
			default: low_rdata = is_low(REQ_I.addr)
				? regs_r[REQ_I.addr[4:0]] : 8'h00; // R01
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			RDATA_O      <= 8'h00;
			RVALID_O     <= 1'b0;
		end else begin
			RVALID_O     <= REQ_I.rd_en;
			if (REQ_I.rd_en) begin
				RDATA_O <= sw_hit ? SW_RDATA_I : low_rdata;
			end
		end
	end

endmodule

// >>> rtl/ldlrb_pkg.sv
// Package: offsets, field masks, reset values and types of the low bank
package ldlrb_pkg;

	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 8;

	// Sub-address offsets
	localparam logic [6:0] OFS_POWER_CONTROL       = 7'h00;
	localparam logic [6:0] OFS_REGULATOR_CONTROL   = 7'h01;
	localparam logic [6:0] OFS_PUMP_STATE          = 7'h02;
	localparam logic [6:0] OFS_PUMP_STATE_OVERRIDE = 7'h03;
	localparam logic [6:0] OFS_FACTORY_TEST        = 7'h04;
	localparam logic [6:0] OFS_CLOCK_SOURCE_SELECT = 7'h05;
	localparam logic [6:0] OFS_OUTPUT_PIN_ENABLE   = 7'h06;
	localparam logic [6:0] OFS_OUTPUT_PIN_LEVEL    = 7'h07;
	localparam logic [6:0] OFS_IO_DIRECTION_SELECT = 7'h08;
	localparam logic [6:0] OFS_IO_OUTPUT_LEVEL     = 7'h09;
	localparam logic [6:0] OFS_IO_VOLTAGE_SELECT   = 7'h0a;
	localparam logic [6:0] OFS_IRQ_STATUS_A        = 7'h0b;
	localparam logic [6:0] OFS_IRQ_CLEAR_A         = 7'h0c;
	localparam logic [6:0] OFS_IRQ_MASK_A          = 7'h0d;
	localparam logic [6:0] OFS_IO_PULLDOWN_CONTROL = 7'h0e;
	localparam logic [6:0] OFS_IO_DETECT_CONFIG    = 7'h0f;
	localparam logic [6:0] OFS_LED_ROUTE_A         = 7'h10;
	localparam logic [6:0] OFS_LED_ROUTE_B         = 7'h11;
	localparam logic [6:0] OFS_LED_SENSE_ENABLE_A  = 7'h12;
	localparam logic [6:0] OFS_LED_SENSE_ENABLE_B  = 7'h13;
	localparam logic [6:0] OFS_LED_SENSE_ENABLE_C  = 7'h14;
	localparam logic [6:0] OFS_IRQ_STATUS_B        = 7'h15;
	localparam logic [6:0] OFS_IRQ_CLEAR_B         = 7'h16;
	localparam logic [6:0] OFS_IRQ_MASK_B          = 7'h17;
	localparam logic [6:0] OFS_SENSOR_RESULT_LOW   = 7'h18;
	localparam logic [6:0] OFS_SENSOR_RESULT_HIGH  = 7'h19;
	localparam logic [6:0] OFS_GAIN_THRESHOLD      = 7'h1a;
	localparam logic [6:0] OFS_GAIN_SWITCH_UPPER   = 7'h1b;
	localparam logic [6:0] OFS_GAIN_SWITCH_LOWER   = 7'h1c;
	localparam logic [6:0] OFS_INT_SOURCE_SELECT   = 7'h1d;
	localparam logic [6:0] OFS_SENSOR_WAIT_TIME    = 7'h1e;
	localparam logic [6:0] OFS_BANK_SELECT         = 7'h1f;
	localparam logic [6:0] OFS_SWITCHED_FIRST      = 7'h20;
	localparam logic [6:0] OFS_SWITCHED_LAST       = 7'h6f;
	localparam int unsigned NUM_LOW_REGS           = 32;

	// Implemented-bit masks, indexed by offset
	localparam logic [7:0] FIELD_MASK [NUM_LOW_REGS] = '{
		8'h1f, 8'h1f, 8'h1f, 8'hff, 8'h00, 8'h03, 8'h3f, 8'h3f,
		8'h07, 8'h07, 8'h07, 8'hff, 8'h47, 8'hc7, 8'h07, 8'h07,
		8'hff, 8'hff, 8'hff, 8'h03, 8'hff, 8'h7f, 8'h7f, 8'h7f,
		8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'h7f, 8'h1f, 8'h03
	};

	// Reset values, indexed by offset
	localparam logic [7:0] RESET_VAL [NUM_LOW_REGS] = '{
		8'h00, 8'h0e, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h08, 8'hfa, 8'h07, 8'h00, 8'h0c, 8'h00
	};

	// Switched map selector codes
	typedef enum logic [1:0] {
		LDLRB_MAP_LED_CHANNELS = 2'b00,
		LDLRB_MAP_MODULATED    = 2'b01,
		LDLRB_MAP_PATTERN_ONE  = 2'b10,
		LDLRB_MAP_PATTERN_TWO  = 2'b11
	} ldlrb_map_t;

	// Host register access request
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [6:0] addr;
		logic [7:0] wdata;
	} ldlrb_req_t;

	// Hardware-owned state reported to the host
	typedef struct packed {
		logic [7:0] pump_state;
		logic [7:0] sensor_low;
		logic [7:0] sensor_high;
	} ldlrb_hw_t;

endpackage

// >>> tb/ldlrb_bank_tb_top.sv
// Testbench for the low register bank
`timescale 1ns/1ps
module ldlrb_bank_tb_top;
	logic                  MCLK_I = 0;
	logic                  RST_N_I = 0;
	ldlrb_pkg::ldlrb_req_t req = '0;
	ldlrb_pkg::ldlrb_hw_t  hw = {8'h01, 8'h00, 8'h00};
	logic [7:0]            evt = 8'h00, rdata, swd, swwd, pa, pb;
	logic [7:0]            ctrl [32];
	logic [6:0]            swa;
	logic [3:0]            sel;
	logic                  rv, swr, sww;
	int                    failures = 0, checks_done = 0, cyc = 0;
	logic [14:0]           sw_seen = '0;
	always #25 MCLK_I = ~MCLK_I;
	ldlrb_bank uut (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .REQ_I(req),
		.RDATA_O(rdata), .RVALID_O(rv), .EVT_A_I(evt), .EVT_B_I(evt),
		.HW_I(hw), .SW_WR_O(sww), .SW_RD_O(swr), .SW_ADDR_O(swa),
		.SW_WDATA_O(swwd), .SW_MAP_SEL_O(sel), .SW_RDATA_I(swd),
		.CTRL_O(ctrl), .IRQ_PEND_A_O(pa), .IRQ_PEND_B_O(pb));
	ldlrb_map_model far (.rd_i(swr), .sel_i(sel), .addr_i(swa),
		.rdata_o(swd));

	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic wr(logic [6:0] a, logic [7:0] d);
		@(negedge MCLK_I) req = '{1'b1, 1'b0, a, d};
		@(negedge MCLK_I) req.wr_en = 1'b0;
	endtask
	task automatic rd(logic [6:0] a, logic [7:0] e);
		@(negedge MCLK_I) req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge MCLK_I) req.rd_en = 1'b0;
		chk({7'h00, rv}, 8'h01);
		chk(rdata, e);
	endtask
	task automatic end_of_test;
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Last switched write seen by the far side
	always @(posedge MCLK_I) begin
		if (sww) sw_seen <= {swa, swwd};
	end

	always @(posedge MCLK_I) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		repeat (8) @(negedge MCLK_I);
		RST_N_I = 1'b1;
		for (int i = 0; i < 32; i++)
			rd(7'(i), ldlrb_pkg::RESET_VAL[i]);
		for (int i = 0; i < 32; i++)
			if (i != 4) wr(7'(i), 8'hff);
		chk(ctrl[2], 8'h01);
		chk(ctrl[4], 8'h00);
		chk(ctrl[31], 8'h03);
		@(negedge MCLK_I) hw = {8'h1f, 8'ha5, 8'h3c};
		rd(7'h02, 8'h1f);
		rd(7'h18, 8'ha5);
		rd(7'h19, 8'h3c);
		@(negedge MCLK_I) hw = {8'h01, 8'h00, 8'h00};
		for (int i = 0; i < 32; i++)
			rd(7'(i), (i inside {2, 4, 11, 12, 21, 22, 24, 25}) ?
				ldlrb_pkg::RESET_VAL[i] : ldlrb_pkg::FIELD_MASK[i]);
		@(negedge MCLK_I) evt = 8'hff;
		@(negedge MCLK_I) evt = 8'h00;
		rd(7'h0b, 8'hff);
		rd(7'h15, 8'h7f);
		chk(pa, 8'hc7);
		chk(pb, 8'h7f);
		wr(7'h0c, 8'hff);
		rd(7'h0b, 8'hb8);
		for (int s = 0; s < 4; s++) begin
			wr(7'h1f, 8'(s));
			chk({4'h0, sel}, 8'(1 << s));
			rd(7'h6f, {4'(1 << s), 4'hf});
			rd(7'h20, {4'(1 << s), 4'h0});
		end
		rd(7'h70, 8'h00);
		wr(7'h35, 8'h5a);
		chk(sw_seen[7:0], 8'h5a);
		chk({1'b0, sw_seen[14:8]}, 8'h35);
		wr(7'h10, 8'h11);
		chk({1'b0, sw_seen[14:8]}, 8'h35);
		chk(ctrl[16], 8'h11);
		end_of_test();
	end
endmodule

// >>> tb/ldlrb_checker.sv
// Assertion checker for the low register bank
`timescale 1ns/1ps
module ldlrb_checker (
	// Clock and reset
	input wire logic                  MCLK_I,
	input wire logic                  RST_N_I,
	// Host access and switched range
	input wire ldlrb_pkg::ldlrb_req_t REQ_I,
	input wire logic [7:0]            RDATA_O,
	input wire logic                  RVALID_O,
	input wire logic                  SW_RD_O,
	input wire logic [3:0]            SW_MAP_SEL_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	wire sel_wr = REQ_I.wr_en && REQ_I.addr == 7'h1f;
	wire sel_rd = REQ_I.rd_en && REQ_I.addr == 7'h1f;

	chk_sel_upper_zero: assert property (
		sel_rd |=> RVALID_O && RDATA_O[7:2] == 6'h00) else $error("sel bits");
	chk_switch_strobe: assert property (
		SW_RD_O == (REQ_I.rd_en && REQ_I.addr inside {[7'h20:7'h6f]}))
		else $error("switched read strobe");
	chk_map_hold: assert property (
		!sel_wr |=> $stable(SW_MAP_SEL_O)) else $error("map moved");
	chk_map_led: assert property (
		sel_wr && REQ_I.wdata[1:0] == 2'b00 |=> SW_MAP_SEL_O == 4'h1)
		else $error("map 00");
	chk_map_mod: assert property (
		sel_wr && REQ_I.wdata[1:0] == 2'b01 |=> SW_MAP_SEL_O == 4'h2)
		else $error("map 01");
	chk_map_pat_one: assert property (
		sel_wr && REQ_I.wdata[1:0] == 2'b10 |=> SW_MAP_SEL_O == 4'h4)
		else $error("map 10");
	chk_map_pat_two: assert property (
		sel_wr && REQ_I.wdata[1:0] == 2'b11 |=> SW_MAP_SEL_O == 4'h8)
		else $error("map 11");
	chk_clear_reads_zero: assert property (
		REQ_I.rd_en && REQ_I.addr == 7'h0c |=> RVALID_O && RDATA_O == 8'h00)
		else $error("clear reg read");
endmodule

bind ldlrb_bank ldlrb_checker u_chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
	.REQ_I(REQ_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
	.SW_RD_O(SW_RD_O), .SW_MAP_SEL_O(SW_MAP_SEL_O));

// >>> tb/ldlrb_map_model.sv
// Far-side model of the four switched register maps
`timescale 1ns/1ps
module ldlrb_map_model (
	// Switched access
	input  wire logic       rd_i,
	input  wire logic [3:0] sel_i,
	input  wire logic [6:0] addr_i,
	// Read data
	output logic      [7:0] rdata_o
);
	// Data names the map; inverted when not read
	assign rdata_o = rd_i ? {sel_i, addr_i[3:0]} : ~{sel_i, addr_i[3:0]};
endmodule
